// ===== shared/rxeq_pkg.sv
package rxeq_pkg;
	// Register offsets
	localparam logic [7:0] RXEQ_OFF_BYPASS   = 8'hD4;
	localparam logic [7:0] RXEQ_OFF_BOUNDS   = 8'hD5;
	localparam logic [7:0] RXEQ_OFF_RSVD_D6  = 8'hD6;
	localparam logic [7:0] RXEQ_OFF_RSVD_D7  = 8'hD7;
	localparam logic [7:0] RXEQ_OFF_IRQ_HIGH = 8'hD8;
	localparam logic [7:0] RXEQ_OFF_IRQ_LOW  = 8'hD9;
	// Values after reset
	localparam logic [7:0] RXEQ_RST_BYPASS   = 8'h60;
	localparam logic [7:0] RXEQ_RST_BOUNDS   = 8'hF2;
	localparam logic [7:0] RXEQ_RST_RSVD     = 8'h00;
	localparam logic [7:0] RXEQ_RST_IRQ      = 8'h00;
	// Field positions in eq_bypass_and_lock_ctrl
	localparam int RXEQ_UPPER_MSB = 7;
	localparam int RXEQ_UPPER_LSB = 5;
	localparam int RXEQ_LOCK_MODE = 4;
	localparam int RXEQ_LOWER_MSB = 3;
	localparam int RXEQ_LOWER_LSB = 1;
	localparam int RXEQ_DISABLE   = 0;
	// Field positions in eq_adapt_bounds
	localparam int RXEQ_CEIL_MSB  = 7;
	localparam int RXEQ_CEIL_LSB  = 4;
	localparam int RXEQ_FLOOR_MSB = 3;
	localparam int RXEQ_FLOOR_LSB = 0;
	// Writable bits of the high enable register
	localparam logic [7:0] RXEQ_HIGH_MASK = 8'h07;
	// Event vector: [9:7] from high enables [2:0], [6:0] from low enables [6:0]
	localparam int RXEQ_NUM_EVENTS = 10;
	localparam logic [9:0] RXEQ_CLR_STATUS_ONE = 10'h187;
	localparam logic [9:0] RXEQ_CLR_STATUS_TWO = 10'h270;
	localparam logic [9:0] RXEQ_CLR_CAMERA     = 10'h008;
endpackage : rxeq_pkg

// ===== core/rxeq_regs.sv
// How it works
// - Separate copy per port, picked by port select
// - Bypass: upper manual bits drive setting[5:3]
// - Bypass: lower manual bits drive setting[2:0]
// - Lock-qualify bit makes lock wait for adaptation when not bypassed
// - Adaptation steps and restarts never go past the four-bit ceiling; a lowered ceiling leaves a higher value in place
// - Floor-start begins adaptation at the lower of the floor and ceiling field values
// - High enable bit 2: encoding error interrupt
// - High enable bit 1: control sequence error
// - High enable bit 0: control frame CRC error
// - Low enable bit 6: line length change
// - Low enable bit 5: line count change
// - Low enable bit 4: receive buffer overflow
// - Low enable bit 3: camera receiver error
// - Low enable bit 2: link parity error
// - Low enable bit 1: port-valid change
// - Low enable bit 0: lock status change
// - Floor-start off means adaptation starts from zero
// - Status-one read clears its pending conditions
`timescale 1ns/1ns
`default_nettype none

module rxeq_regs
	import rxeq_pkg::*;
#(
	parameter int NUM_PORTS = 2,
	parameter int SEL_W     = 1
) (
	input  wire logic                                  clk_in,
	input  wire logic                                  reset_in,
	input  wire logic [SEL_W-1:0]                      port_sel_in,
	input  wire logic [7:0]                            reg_addr_in,
	input  wire logic [7:0]                            reg_wdata_in,
	input  wire logic                                  reg_wr_in,
	input  wire logic                                  reg_rd_in,
	output logic      [7:0]                            reg_rdata_out,
	input  wire logic [NUM_PORTS-1:0]                  eq_floor_start_enable_in,
	input  wire logic [NUM_PORTS-1:0]                  eq_restart_in,
	input  wire logic [NUM_PORTS-1:0]                  eq_step_in,
	input  wire logic [NUM_PORTS-1:0]                  eq_done_in,
	input  wire logic [NUM_PORTS-1:0]                  lock_raw_in,
	input  wire logic [NUM_PORTS-1:0][RXEQ_NUM_EVENTS-1:0] event_in,
	input  wire logic [NUM_PORTS-1:0]                  status_one_read_in,
	input  wire logic [NUM_PORTS-1:0]                  status_two_read_in,
	input  wire logic [NUM_PORTS-1:0]                  camera_status_read_in,
	output logic      [NUM_PORTS-1:0][5:0]             eq_setting_out,
	output logic      [NUM_PORTS-1:0]                  lock_out,
	output logic      [NUM_PORTS-1:0]                  irq_out
);

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [NUM_PORTS-1:0][7:0]                 bypass;
		logic [NUM_PORTS-1:0][7:0]                 bounds;
		logic [NUM_PORTS-1:0][7:0]                 rsvd_d6;
		logic [NUM_PORTS-1:0][7:0]                 rsvd_d7;
		logic [NUM_PORTS-1:0][2:0]                 en_high;
		logic [NUM_PORTS-1:0][7:0]                 en_low;
		logic [NUM_PORTS-1:0][RXEQ_NUM_EVENTS-1:0] pending;
		logic [NUM_PORTS-1:0][5:0]                 adapt;
		logic [NUM_PORTS-1:0]                      adapt_done;
		logic [NUM_PORTS-1:0][5:0]                 setting;
		logic [NUM_PORTS-1:0]                      lock;
		logic [7:0]                                rdata;
	} rxeq_state_t;

	rxeq_state_t state_reg;
	rxeq_state_t state_next;

	logic [RXEQ_NUM_EVENTS-1:0] clear_mask;
	logic [5:0]                 ceiling;
	logic [5:0]                 start_val;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		clear_mask = '0;
		ceiling = '0;
		start_val = '0;
		state_next = state_reg;
		// Register writes land in the selected port's copy only
		if (reg_wr_in) begin
			case (reg_addr_in)
				RXEQ_OFF_BYPASS:   state_next.bypass[port_sel_in] = reg_wdata_in;
				RXEQ_OFF_BOUNDS:   state_next.bounds[port_sel_in] = reg_wdata_in;
				RXEQ_OFF_RSVD_D6:  state_next.rsvd_d6[port_sel_in] = reg_wdata_in;
				RXEQ_OFF_RSVD_D7:  state_next.rsvd_d7[port_sel_in] = reg_wdata_in;
				RXEQ_OFF_IRQ_HIGH: state_next.en_high[port_sel_in] =
					reg_wdata_in[2:0];
				RXEQ_OFF_IRQ_LOW:  state_next.en_low[port_sel_in] = reg_wdata_in;
				default: ;
			endcase
		end
		// Read data captured from the selected copy
		if (reg_rd_in) begin
			case (reg_addr_in)
				RXEQ_OFF_BYPASS:   state_next.rdata = state_reg.bypass[port_sel_in];
				RXEQ_OFF_BOUNDS:   state_next.rdata = state_reg.bounds[port_sel_in];
				RXEQ_OFF_RSVD_D6:  state_next.rdata = state_reg.rsvd_d6[port_sel_in];
				RXEQ_OFF_RSVD_D7:  state_next.rdata = state_reg.rsvd_d7[port_sel_in];
				RXEQ_OFF_IRQ_HIGH: state_next.rdata =
					{5'h00, state_reg.en_high[port_sel_in]} & RXEQ_HIGH_MASK;
				RXEQ_OFF_IRQ_LOW:  state_next.rdata = state_reg.en_low[port_sel_in];
				default:           state_next.rdata = 8'h00;
			endcase
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			// Pending conditions: a new event wins over a clearing read
			clear_mask = '0;
			if (status_one_read_in[p])
				clear_mask = clear_mask | RXEQ_CLR_STATUS_ONE;
			if (status_two_read_in[p])
				clear_mask = clear_mask | RXEQ_CLR_STATUS_TWO;
			if (camera_status_read_in[p])
				clear_mask = clear_mask | RXEQ_CLR_CAMERA;
			state_next.pending[p] = (state_reg.pending[p] & ~clear_mask) | event_in[p];
			// Adaptation walk, bounded by the ceiling
			ceiling = {2'h0, state_reg.bounds[p][RXEQ_CEIL_MSB:RXEQ_CEIL_LSB]};
			start_val = eq_floor_start_enable_in[p] ?
				{2'h0, state_reg.bounds[p][RXEQ_FLOOR_MSB:RXEQ_FLOOR_LSB]} : 6'h00;
			if (start_val > ceiling)
				start_val = ceiling;
			if (eq_restart_in[p]) begin
				state_next.adapt[p] = start_val;
				state_next.adapt_done[p] = 1'b0;
			end else if (eq_done_in[p]) begin
				state_next.adapt_done[p] = 1'b1;
			end else if (eq_step_in[p] && !state_reg.adapt_done[p]) begin
				if (state_reg.adapt[p] < ceiling)
					state_next.adapt[p] = state_reg.adapt[p] + 6'h01;
				else
					state_next.adapt_done[p] = 1'b1;
			end
			// Applied setting: manual fields when bypassed
			if (state_reg.bypass[p][RXEQ_DISABLE])
				state_next.setting[p] = {
					state_reg.bypass[p][RXEQ_UPPER_MSB:RXEQ_UPPER_LSB],
					state_reg.bypass[p][RXEQ_LOWER_MSB:RXEQ_LOWER_LSB]};
			else
				state_next.setting[p] = state_reg.adapt[p];
			// Lock qualification
			state_next.lock[p] = lock_raw_in[p] &
				(~state_reg.bypass[p][RXEQ_LOCK_MODE] | state_reg.adapt_done[p]
				| state_reg.bypass[p][RXEQ_DISABLE]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				state_reg.bypass[p]     <= RXEQ_RST_BYPASS;
				state_reg.bounds[p]     <= RXEQ_RST_BOUNDS;
				state_reg.rsvd_d6[p]    <= RXEQ_RST_RSVD;
				state_reg.rsvd_d7[p]    <= RXEQ_RST_RSVD;
				state_reg.en_high[p]    <= 3'h0;
				state_reg.en_low[p]     <= RXEQ_RST_IRQ;
				state_reg.pending[p]    <= '0;
				state_reg.adapt[p]      <= 6'h00;
				state_reg.adapt_done[p] <= 1'b0;
				state_reg.setting[p]    <= 6'h00;
				state_reg.lock[p]       <= 1'b0;
			end
			state_reg.rdata <= 8'h00;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign reg_rdata_out = state_reg.rdata;

	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
		assign eq_setting_out[g] = state_reg.setting[g];
		assign lock_out[g] = state_reg.lock[g];
		// Enabled pending conditions OR into the port request
		// High enables gate events 9:7, low enables gate events 6:0
		assign irq_out[g] = |(state_reg.pending[g] &
			{state_reg.en_high[g], state_reg.en_low[g][6:0]});
	end

endmodule : rxeq_regs

`default_nettype wire

// ===== verification/rxeq_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module rxeq_regs_chk
	import rxeq_pkg::*;
#(
	parameter int NUM_PORTS = 2
) (
	input wire logic                                      clk_in,
	input wire logic                                      reset_in,
	input wire logic [7:0]                                reg_addr_in,
	input wire logic                                      reg_wr_in,
	input wire logic                                      reg_rd_in,
	input wire logic [7:0]                                reg_rdata_out,
	input wire logic [NUM_PORTS-1:0]                      eq_restart_in,
	input wire logic [NUM_PORTS-1:0]                      eq_done_in,
	input wire logic [NUM_PORTS-1:0]                      lock_raw_in,
	input wire logic [NUM_PORTS-1:0][RXEQ_NUM_EVENTS-1:0] event_in,
	input wire logic [NUM_PORTS-1:0]                      status_one_read_in,
	input wire logic [NUM_PORTS-1:0]                      status_two_read_in,
	input wire logic [NUM_PORTS-1:0]                      camera_status_read_in,
	input wire logic [NUM_PORTS-1:0][5:0]                 eq_setting_out,
	input wire logic [NUM_PORTS-1:0]                      lock_out,
	input wire logic [NUM_PORTS-1:0]                      irq_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_reset_outputs_zero: assert property ($fell(reset_in) |-> !irq_out && !lock_out
		&& eq_setting_out == '0 && reg_rdata_out == 8'h00) else $error("outputs not clear");
	a_high_rsvd_zero: assert property (reg_rd_in && reg_addr_in == RXEQ_OFF_IRQ_HIGH
		|=> reg_rdata_out[7:3] == 5'h00) else $error("high enable reserved bits set");
	a_unmapped_reads_zero: assert property (reg_rd_in && (reg_addr_in < RXEQ_OFF_BYPASS
		|| reg_addr_in > RXEQ_OFF_IRQ_LOW) |=> reg_rdata_out == 8'h00) else $error("unmapped data");
	a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data moved without read");
	a_irq_has_cause: assert property ($rose(irq_out[0]) |-> $past(event_in[0] != '0)
		|| $past(reg_wr_in)) else $error("interrupt without cause");
	a_irq_pending_holds: assert property (irq_out[0] && !(status_one_read_in[0]
		|| status_two_read_in[0] || camera_status_read_in[0] || reg_wr_in) |=> irq_out[0])
		else $error("interrupt dropped without clear");
	a_lock_needs_raw: assert property (!lock_raw_in[0] |=> !lock_out[0])
		else $error("lock without raw lock");
	a_lock_after_done: assert property (eq_done_in[0] && !eq_restart_in[0] ##1 lock_raw_in[0]
		|=> lock_out[0]) else $error("no lock after adaptation done");
endmodule : rxeq_regs_chk
bind rxeq_regs rxeq_regs_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.clk_in, .reset_in, .reg_addr_in,
	.reg_wr_in, .reg_rd_in, .reg_rdata_out, .eq_restart_in, .eq_done_in, .lock_raw_in, .event_in,
	.status_one_read_in, .status_two_read_in, .camera_status_read_in, .eq_setting_out, .lock_out,
	.irq_out);
`default_nettype wire

// ===== verification/rxeq_host.sv
`timescale 1ns/1ns
`default_nettype none
module rxeq_host (
	input  wire logic       clk_in,
	input  wire logic [7:0] reg_rdata_in,
	output logic            port_sel_out,
	output logic      [7:0] reg_addr_out,
	output logic      [7:0] reg_wdata_out,
	output logic            reg_wr_out,
	output logic            reg_rd_out
);
	initial begin
		{port_sel_out, reg_addr_out, reg_wdata_out, reg_wr_out, reg_rd_out} = '0;
	end
	// One strobe cycle, then address and data lines show the inverse of the last value
	task automatic access(input logic p, input logic [7:0] a, d, input logic w,
			output logic [7:0] q);
		@(negedge clk_in);
		port_sel_out = p;
		reg_addr_out = a;
		reg_wdata_out = d;
		{reg_wr_out, reg_rd_out} = {w, !w};
		@(negedge clk_in);
		{reg_wr_out, reg_rd_out} = 2'b00;
		reg_addr_out = ~a;
		reg_wdata_out = ~d;
		@(negedge clk_in);
		q = reg_rdata_in;
	endtask : access
endmodule : rxeq_host
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import rxeq_pkg::*;
	logic                 clk_in, reset_in, port_sel_in, reg_wr_in, reg_rd_in;
	logic [7:0]           reg_addr_in, reg_wdata_in, reg_rdata_out, q, r;
	logic [1:0]           eq_floor_start_enable_in, eq_restart_in, eq_step_in, eq_done_in;
	logic [1:0]           lock_raw_in, status_one_read_in, status_two_read_in, lock_out, irq_out;
	logic [1:0]           camera_status_read_in;
	logic [1:0][9:0]      event_in;
	logic [1:0][5:0]      eq_setting_out;
	logic [2:0]           m;
	int                   err_count, comparisons, seed, i, p;
	rxeq_regs dut (.clk_in, .reset_in, .port_sel_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .eq_floor_start_enable_in, .eq_restart_in, .eq_step_in,
		.eq_done_in, .lock_raw_in, .event_in, .status_one_read_in, .status_two_read_in,
		.camera_status_read_in, .eq_setting_out, .lock_out, .irq_out);
	rxeq_host host (.clk_in, .reg_rdata_in(reg_rdata_out), .port_sel_out(port_sel_in),
		.reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in),
		.reg_rd_out(reg_rd_in));
	task automatic chk(input logic [7:0] g, e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic p, input logic [7:0] a, d);
		host.access(p, a, d, 1'b1, q);
	endtask : wr
	task automatic rc(input logic p, input logic [7:0] a, e);
		host.access(p, a, 8'h00, 1'b0, q);
		chk(q, e);
	endtask : rc
	// Kind bits: restart, step, done on port 0
	task automatic pulse(input logic [2:0] k);
		@(negedge clk_in);
		{eq_restart_in[0], eq_step_in[0], eq_done_in[0]} = k;
		@(negedge clk_in);
		{eq_restart_in[0], eq_step_in[0], eq_done_in[0]} = 3'b000;
		repeat (2) @(negedge clk_in);
	endtask : pulse
	task automatic clr(input logic [2:0] k);
		@(negedge clk_in);
		{status_one_read_in[0], status_two_read_in[0], camera_status_read_in[0]} = k;
		@(negedge clk_in);
		{status_one_read_in[0], status_two_read_in[0], camera_status_read_in[0]} = 3'b000;
		@(negedge clk_in);
	endtask : clr
	task automatic conclude;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	initial begin
		#2000000;
		err_count++;
		conclude();
	end
	initial begin
		seed = 32'h66C2;
		{eq_floor_start_enable_in, eq_restart_in, eq_step_in, eq_done_in, lock_raw_in} = '0;
		{status_one_read_in, status_two_read_in, camera_status_read_in, event_in} = '0;
		reset_in = 1'b1;
		repeat (10) @(negedge clk_in);
		reset_in = 1'b0;
		for (p = 0; p < 2; p++)
			for (i = 0; i < 6; i++)
				rc(p[0], 8'(RXEQ_OFF_BYPASS + i), i == 0 ? RXEQ_RST_BYPASS :
					(i == 1 ? RXEQ_RST_BOUNDS : 8'h00));
		rc(0, 8'hE0, 8'h00);
		wr(0, RXEQ_OFF_IRQ_HIGH, 8'hFF);
		rc(0, RXEQ_OFF_IRQ_HIGH, RXEQ_HIGH_MASK);
		r = 8'($random(seed));
		wr(1, RXEQ_OFF_BOUNDS, r);
		rc(0, RXEQ_OFF_BOUNDS, RXEQ_RST_BOUNDS);
		rc(1, RXEQ_OFF_BOUNDS, r);
		wr(0, RXEQ_OFF_IRQ_HIGH, 8'h00);
		for (i = 0; i < 5; i++) begin
			r = i == 0 ? 8'hEF : (8'($random(seed)) & 8'hEE) | 8'h01;
			wr(0, RXEQ_OFF_BYPASS, r);
			chk(8'(eq_setting_out[0]), {2'b00, r[7:5], r[3:1]});
		end
		wr(0, RXEQ_OFF_BYPASS, 8'h00);
		eq_floor_start_enable_in[0] = 1'b1;
		pulse(3'b100);
		chk(8'(eq_setting_out[0]), 8'h02);
		eq_floor_start_enable_in[0] = 1'b0;
		pulse(3'b100);
		chk(8'(eq_setting_out[0]), 8'h00);
		wr(0, RXEQ_OFF_BOUNDS, 8'h31);
		eq_floor_start_enable_in[0] = 1'b1;
		pulse(3'b100);
		chk(8'(eq_setting_out[0]), 8'h01);
		repeat (4) pulse(3'b010);
		chk(8'(eq_setting_out[0]), 8'h03);
		wr(0, RXEQ_OFF_BYPASS, 8'h10);
		lock_raw_in[0] = 1'b1;
		pulse(3'b100);
		chk(8'(lock_out[0]), 8'h00);
		pulse(3'b001);
		chk(8'(lock_out[0]), 8'h01);
		wr(0, RXEQ_OFF_BYPASS, 8'h00);
		pulse(3'b100);
		chk(8'(lock_out[0]), 8'h01);
		for (i = 0; i < 10; i++) begin
			@(negedge clk_in);
			event_in[0] = 10'(1 << i);
			@(negedge clk_in);
			event_in[0] = '0;
			chk(8'(irq_out[0]), 8'h00);
			r = 8'(i > 6 ? 1 << (i - 7) : 1 << i);
			wr(0, i > 6 ? RXEQ_OFF_IRQ_HIGH : RXEQ_OFF_IRQ_LOW, r);
			chk(8'(irq_out[0]), 8'h01);
			m = {RXEQ_CLR_STATUS_ONE[i], RXEQ_CLR_STATUS_TWO[i], RXEQ_CLR_CAMERA[i]};
			clr(~m);
			chk(8'(irq_out[0]), 8'h01);
			clr(m);
			chk(8'(irq_out[0]), 8'h00);
			wr(0, i > 6 ? RXEQ_OFF_IRQ_HIGH : RXEQ_OFF_IRQ_LOW, 8'h00);
		end
		conclude();
	end
endmodule : tb_top
`default_nettype wire
